/* File: hdl/sbd_pkg.sv */
package sbd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // Register word indices on the plain register port
  localparam logic [7:0] REG_EVENT = 8'h00;
  localparam logic [7:0] REG_ENABLE = 8'h01;
  localparam logic [7:0] REG_MODE = 8'h02;
  localparam logic [7:0] REG_RX_BASE = 8'h03;
  localparam logic [7:0] REG_TX_BASE = 8'h04;
  localparam logic [7:0] REG_RX_CHUNK = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h06;
  // Upper address bits select the descriptor RAM or the buffer RAM
  localparam logic [1:0] BD_WINDOW = 2'b01;
  localparam int BUF_SEL_BIT = 7;
  localparam int BD_DEPTH = 64;
  localparam int BUF_DEPTH = 128;
  // Descriptor halfword offsets
  localparam logic [5:0] BD_OFS_LEN = 6'h01;
  localparam logic [5:0] BD_OFS_PTR_LO = 6'h03;
  localparam logic [5:0] BD_STRIDE = 6'h04;
  // Descriptor status bits
  localparam int BD_OWN = 15;
  localparam int BD_WRAP = 13;
  localparam int BD_INT = 12;
  localparam int BD_LAST = 11;
  localparam int BD_REPEAT = 9;
  localparam int BD_ERR = 1;
  localparam int BD_CLASH = 0;
  // Event bits, shared by flags and enables
  localparam int EV_CLASH = 5;
  localparam int EV_TX_FAULT = 4;
  localparam int EV_NO_BUF = 2;
  localparam int EV_TX_DONE = 1;
  localparam int EV_RX_DONE = 0;
  localparam logic [7:0] EV_IMPL = 8'h37;
  // Mode bits
  localparam int MODE_MASTER = 0;
  localparam int MODE_RX_EN = 1;
  localparam int MODE_TX_EN = 2;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [7:0] EV_RESET = 8'h00;
  localparam logic [15:0] CHUNK_RESET = 16'h0010;
endpackage : sbd_pkg

/* File: hdl/sbd_sync2.sv */
`timescale 1ns/1ns
`default_nettype none
module sbd_sync2 (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_reg;

  // Reset to one: the select pin idles high
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= 1'b1;
      q <= 1'b1;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sbd_sync2
`default_nettype wire

/* File: hdl/sbd_events.sv */
// Contract
// [RULE_01] Empty flag set: controller owns receive descriptor; clear: controller leaves it alone.
// [RULE_02] Controller clears empty flag when buffer is full or reception aborted.
// [RULE_03] After a wrap descriptor, receive continues at the receive ring base.
// [RULE_04] Receive interrupt flag set: receive-done event once buffer filled.
// [RULE_05] Master with repeat flag: empty flag kept; host writes zero in slave.
// [RULE_06] Slave: last flag set when select negation closes the buffer.
// [RULE_07] Slave: overflow flag set on receiver overrun in that buffer.
// [RULE_08] Master: external select closes current descriptors with clash flag.
// [RULE_09] Closing a receive descriptor writes the stored octet count once.
// [RULE_10] Host supplies an even receive buffer pointer at offsets 4 and 6.
// [RULE_11] Ready flag set: controller owns transmit descriptor; cleared when done.
// [RULE_12] After a wrap transmit descriptor, continue at the transmit ring base.
// [RULE_13] Transmit interrupt flag set: done or fault event when serviced.
// [RULE_14] Master with repeat flag: ready flag kept, buffer resent next pass.
// [RULE_15] Slave: starved flag set on transmitter underrun in that buffer.
// [RULE_16] Controller sends transmit length octets and never writes that field.
// [RULE_17] Transmit pointer may be odd unless characters exceed eight bits.
// [RULE_18] 8-bit event register with clash, fault, no-buffer, tx-done, rx-done bits.
// [RULE_19] Write one clears an event bit; reads any time; zero after reset.
// [RULE_20] Interrupt request stays high while any enabled event bit is set.
// [RULE_21] Master: externally asserted select sets the clash event.
// [RULE_22] Slave transmit underrun sets the transmit fault event.
// [RULE_23] 8-bit enable register, same layout, gates events; zero after reset.
// [RULE_24] First character with no receive buffer sets no-buffer event, is dropped.
// [RULE_25] Transmit-done event once the last character is handed to the engine.
// [RULE_26] Receive-done event after last character stored and descriptor closed.
`timescale 1ns/1ns
`default_nettype none
module sbd_events (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  output logic master_mode,
  input wire logic slave_select_input_n,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_overrun,
  input wire logic tx_char_req,
  output logic tx_char_valid,
  output logic [7:0] tx_char_data,
  input wire logic tx_underrun
);
  typedef enum logic [0:0] {TX_IDLE, TX_SEND} sbd_tx_state_type;

  logic [15:0] bd_mem [0:sbd_pkg::BD_DEPTH-1];
  logic [7:0] buf_mem [0:sbd_pkg::BUF_DEPTH-1];

  logic [7:0] serial_port_event_flags_reg;
  logic [7:0] serial_port_event_enables_reg;
  logic [2:0] mode_reg;
  logic [5:0] rx_ring_base_reg;
  logic [5:0] tx_ring_base_reg;
  logic [15:0] max_rx_chunk_length_reg;
  logic [5:0] rx_ptr_reg;
  logic [5:0] tx_ptr_reg;
  logic [15:0] rx_cnt_reg;
  logic [15:0] tx_cnt_reg;
  logic busy_seen_reg;
  logic sel_prev_reg;
  sbd_tx_state_type tx_state_reg;

  logic sel_sync;
  logic sel_active;
  logic sel_assert;
  logic sel_negate;
  logic clash;
  logic host_bd_wr;
  logic host_buf_wr;

  function automatic logic [5:0] ring_next(input logic [5:0] ptr, input logic wrap,
                                           input logic [5:0] base);
    ring_next = wrap ? base : ptr + sbd_pkg::BD_STRIDE;
  endfunction : ring_next
  function automatic logic [6:0] buf_index(input logic [15:0] ptr_lo, input logic [15:0] cnt);
    buf_index = ptr_lo[6:0] + cnt[6:0];
  endfunction : buf_index

  sbd_sync2 sel_sync_inst (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .d(slave_select_input_n),
    .q(sel_sync)
  );

  assign master_mode = mode_reg[sbd_pkg::MODE_MASTER];
  assign sel_active = ~sel_sync;
  assign sel_assert = sel_active & ~sel_prev_reg;
  assign sel_negate = ~sel_active & sel_prev_reg;
  // Only an assertion edge counts, so a held select reports one clash
  assign clash = master_mode & sel_assert; // [RULE_21]
  assign host_bd_wr = reg_wr & (reg_addr[7:6] == sbd_pkg::BD_WINDOW);
  assign host_buf_wr = reg_wr & reg_addr[sbd_pkg::BUF_SEL_BIT];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_prev_reg <= 1'b0;
    end else if (ce) begin
      sel_prev_reg <= sel_active;
    end
  end

  // Receive side
  logic [15:0] rx_status;
  logic [15:0] rx_ptr_lo;
  logic rx_owned;
  logic rx_store;
  logic [15:0] rx_cnt_after;
  logic rx_full;
  logic rx_ovr;
  logic rx_neg;
  logic rx_clash;
  logic rx_close;
  logic rx_keep;
  logic [15:0] rx_status_next;
  logic rx_no_buf;

  assign rx_status = bd_mem[rx_ptr_reg];
  assign rx_ptr_lo = bd_mem[rx_ptr_reg + sbd_pkg::BD_OFS_PTR_LO]; // [RULE_10]
  assign rx_owned = mode_reg[sbd_pkg::MODE_RX_EN] & rx_status[sbd_pkg::BD_OWN]; // [RULE_01]
  assign rx_store = rx_owned & rx_char_valid;
  assign rx_cnt_after = rx_cnt_reg + {15'h0000, rx_store};
  assign rx_full = rx_store & (rx_cnt_after >= max_rx_chunk_length_reg);
  assign rx_ovr = rx_owned & ~master_mode & rx_overrun; // [RULE_07]
  assign rx_neg = rx_owned & ~master_mode & sel_negate & (rx_cnt_after != 16'h0000); // [RULE_06]
  assign rx_clash = rx_owned & clash; // [RULE_08]
  assign rx_close = rx_full | rx_ovr | rx_neg | rx_clash; // [RULE_02]
  // Repeat buffers only survive a clean fill; errors hand the buffer back
  assign rx_keep = master_mode & rx_status[sbd_pkg::BD_REPEAT] & ~rx_clash; // [RULE_05]
  assign rx_no_buf = mode_reg[sbd_pkg::MODE_RX_EN] & rx_char_valid & ~rx_owned;

  always_comb begin
    rx_status_next = rx_status;
    rx_status_next[sbd_pkg::BD_OWN] = rx_keep; // [RULE_02]
    rx_status_next[sbd_pkg::BD_LAST] = rx_neg; // [RULE_06]
    rx_status_next[sbd_pkg::BD_ERR] = rx_ovr; // [RULE_07]
    rx_status_next[sbd_pkg::BD_CLASH] = rx_clash; // [RULE_08]
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_cnt_reg <= 16'h0000;
      rx_ptr_reg <= 6'h00;
    end else if (ce) begin
      if (reg_wr && reg_addr == sbd_pkg::REG_RX_BASE) begin
        rx_ptr_reg <= {reg_wdata[5:2], 2'b00};
        rx_cnt_reg <= 16'h0000;
      end else if (rx_close) begin
        rx_cnt_reg <= 16'h0000;
        rx_ptr_reg <= ring_next(rx_ptr_reg, rx_status[sbd_pkg::BD_WRAP],
                                rx_ring_base_reg); // [RULE_03]
      end else begin
        rx_cnt_reg <= rx_cnt_after;
      end
    end
  end

  // Reports only the first dropped character until a buffer shows up again
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_seen_reg <= 1'b0;
    end else if (ce) begin
      if (rx_owned) begin
        busy_seen_reg <= 1'b0;
      end else if (rx_no_buf) begin
        busy_seen_reg <= 1'b1; // [RULE_24]
      end
    end
  end

  // Transmit side
  logic [15:0] tx_status;
  logic [15:0] tx_len;
  logic [15:0] tx_ptr_lo;
  logic tx_give;
  logic [15:0] tx_cnt_after;
  logic tx_unr;
  logic tx_clash;
  logic tx_close;
  logic tx_keep;
  logic [15:0] tx_status_next;

  assign tx_status = bd_mem[tx_ptr_reg];
  assign tx_len = bd_mem[tx_ptr_reg + sbd_pkg::BD_OFS_LEN];
  assign tx_ptr_lo = bd_mem[tx_ptr_reg + sbd_pkg::BD_OFS_PTR_LO]; // [RULE_17]
  assign tx_give = (tx_state_reg == TX_SEND) & tx_char_req & (tx_cnt_reg < tx_len); // [RULE_16]
  assign tx_cnt_after = tx_cnt_reg + {15'h0000, tx_give};
  assign tx_unr = (tx_state_reg == TX_SEND) & ~master_mode & tx_underrun; // [RULE_15]
  assign tx_clash = (tx_state_reg == TX_SEND) & clash; // [RULE_08]
  assign tx_close = (tx_state_reg == TX_SEND) & ((tx_cnt_after >= tx_len) | tx_unr | tx_clash);
  assign tx_keep = master_mode & tx_status[sbd_pkg::BD_REPEAT] & ~tx_clash; // [RULE_14]

  always_comb begin
    tx_status_next = tx_status;
    tx_status_next[sbd_pkg::BD_OWN] = tx_keep; // [RULE_11]
    tx_status_next[sbd_pkg::BD_ERR] = tx_unr; // [RULE_15]
    tx_status_next[sbd_pkg::BD_CLASH] = tx_clash; // [RULE_08]
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 16'h0000;
      tx_ptr_reg <= 6'h00;
    end else if (ce) begin
      if (reg_wr && reg_addr == sbd_pkg::REG_TX_BASE) begin
        tx_state_reg <= TX_IDLE;
        tx_ptr_reg <= {reg_wdata[5:2], 2'b00};
        tx_cnt_reg <= 16'h0000;
      end else begin
        case (tx_state_reg)
          TX_IDLE: begin
            tx_cnt_reg <= 16'h0000;
            if (mode_reg[sbd_pkg::MODE_TX_EN] && tx_status[sbd_pkg::BD_OWN]) begin
              tx_state_reg <= TX_SEND; // [RULE_11]
            end
          end
          TX_SEND: begin
            if (tx_close) begin
              tx_state_reg <= TX_IDLE;
              tx_cnt_reg <= 16'h0000;
              tx_ptr_reg <= ring_next(tx_ptr_reg, tx_status[sbd_pkg::BD_WRAP],
                                      tx_ring_base_reg); // [RULE_12]
            end else begin
              tx_cnt_reg <= tx_cnt_after;
            end
          end
          default: begin
            tx_state_reg <= TX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_char_valid <= 1'b0;
      tx_char_data <= 8'h00;
    end else if (ce) begin
      tx_char_valid <= tx_give;
      if (tx_give) begin
        tx_char_data <= buf_mem[buf_index(tx_ptr_lo, tx_cnt_reg)];
      end
    end
  end

  // Descriptor RAM: controller writes land after host writes so they win a same-word race
  always_ff @(posedge clk) begin
    if (ce) begin
      if (host_bd_wr) begin
        bd_mem[reg_addr[5:0]] <= reg_wdata;
      end
      if (rx_close) begin
        bd_mem[rx_ptr_reg] <= rx_status_next;
        bd_mem[rx_ptr_reg + sbd_pkg::BD_OFS_LEN] <= rx_cnt_after; // [RULE_09]
      end
      if (tx_close) begin
        bd_mem[tx_ptr_reg] <= tx_status_next; // [RULE_16]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (host_buf_wr) begin
        buf_mem[reg_addr[6:0]] <= reg_wdata[7:0];
      end
      if (rx_store) begin
        buf_mem[buf_index(rx_ptr_lo, rx_cnt_reg)] <= rx_char_data;
      end
    end
  end

  // Events
  logic [7:0] ev_set;
  logic [7:0] ev_clr;

  always_comb begin
    ev_set = 8'h00;
    ev_set[sbd_pkg::EV_CLASH] = clash; // [RULE_21]
    ev_set[sbd_pkg::EV_TX_FAULT] = tx_close & tx_status[sbd_pkg::BD_INT]
                                   & (tx_unr | tx_clash); // [RULE_22] [RULE_13]
    ev_set[sbd_pkg::EV_NO_BUF] = rx_no_buf & ~busy_seen_reg; // [RULE_24]
    ev_set[sbd_pkg::EV_TX_DONE] = tx_close & tx_status[sbd_pkg::BD_INT]
                                  & ~tx_unr & ~tx_clash; // [RULE_25] [RULE_13]
    ev_set[sbd_pkg::EV_RX_DONE] = rx_close & rx_status[sbd_pkg::BD_INT]; // [RULE_04] [RULE_26]
  end

  assign ev_clr = (reg_wr && reg_addr == sbd_pkg::REG_EVENT) ? reg_wdata[7:0] : 8'h00;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      serial_port_event_flags_reg <= sbd_pkg::EV_RESET; // [RULE_19]
    end else if (ce) begin
      serial_port_event_flags_reg <= ((serial_port_event_flags_reg & ~ev_clr) | ev_set)
                                     & sbd_pkg::EV_IMPL; // [RULE_18] [RULE_19]
    end
  end

  assign irq = |(serial_port_event_flags_reg & serial_port_event_enables_reg); // [RULE_20]

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      serial_port_event_enables_reg <= sbd_pkg::EV_RESET;
      mode_reg <= sbd_pkg::MODE_RESET;
      rx_ring_base_reg <= 6'h00;
      tx_ring_base_reg <= 6'h00;
      max_rx_chunk_length_reg <= sbd_pkg::CHUNK_RESET;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        sbd_pkg::REG_ENABLE: begin
          serial_port_event_enables_reg <= reg_wdata[7:0] & sbd_pkg::EV_IMPL; // [RULE_23]
        end
        sbd_pkg::REG_MODE: begin
          mode_reg <= reg_wdata[2:0];
        end
        sbd_pkg::REG_RX_BASE: begin
          rx_ring_base_reg <= {reg_wdata[5:2], 2'b00};
        end
        sbd_pkg::REG_TX_BASE: begin
          tx_ring_base_reg <= {reg_wdata[5:2], 2'b00};
        end
        sbd_pkg::REG_RX_CHUNK: begin
          max_rx_chunk_length_reg <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        if (reg_addr[sbd_pkg::BUF_SEL_BIT]) begin
          reg_rdata <= {8'h00, buf_mem[reg_addr[6:0]]};
        end else if (reg_addr[7:6] == sbd_pkg::BD_WINDOW) begin
          reg_rdata <= bd_mem[reg_addr[5:0]];
        end else begin
          case (reg_addr)
            sbd_pkg::REG_EVENT: reg_rdata <= {8'h00, serial_port_event_flags_reg};
            sbd_pkg::REG_ENABLE: reg_rdata <= {8'h00, serial_port_event_enables_reg};
            sbd_pkg::REG_MODE: reg_rdata <= {13'h0000, mode_reg};
            sbd_pkg::REG_RX_BASE: reg_rdata <= {10'h000, rx_ring_base_reg};
            sbd_pkg::REG_TX_BASE: reg_rdata <= {10'h000, tx_ring_base_reg};
            sbd_pkg::REG_RX_CHUNK: reg_rdata <= max_rx_chunk_length_reg;
            sbd_pkg::REG_STATUS: reg_rdata <= {1'b0, tx_state_reg == TX_SEND, tx_ptr_reg,
                                               2'b00, rx_ptr_reg};
            default: reg_rdata <= 16'h0000;
          endcase
        end
      end
    end
  end
endmodule : sbd_events
`default_nettype wire

/* File: testbench/sbd_events_props.sv */
`timescale 1ns/1ns
`default_nettype none
module sbd_events_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic irq,
  input wire logic master_mode,
  input wire logic rx_char_valid,
  input wire logic rx_overrun,
  input wire logic tx_char_req,
  input wire logic tx_char_valid,
  input wire logic [7:0] tx_char_data,
  input wire logic tx_underrun
);
  logic [7:0] en_sh;
  logic quiet;
  logic ev_rd;
  // Shadow of the enables so irq can be judged against a read of the flags
  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_sh <= 8'h00;
    end else if (reg_wr && reg_addr == sbd_pkg::REG_ENABLE) begin
      en_sh <= reg_wdata[7:0];
    end
  end
  assign quiet = !rx_char_valid && !rx_overrun && !tx_underrun && !tx_char_valid;
  assign ev_rd = reg_rd && reg_addr == sbd_pkg::REG_EVENT;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_ev_layout;
    ev_rd |=> (reg_rdata & 16'hFFC8) == 16'h0000;
  endproperty
  a_ev_layout: assert property (p_ev_layout) else $error("reserved event bit set");
  property p_irq_fall;
    $fell(irq) |-> $past(reg_wr) && ($past(reg_addr) <= sbd_pkg::REG_ENABLE);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped with no clear");
  property p_irq_match;
    ev_rd |=> (|(reg_rdata[7:0] & en_sh)) == $past(irq);
  endproperty
  a_irq_match: assert property (p_irq_match) else $error("irq disagrees with flags");
  property p_en_zero;
    reg_wr && reg_addr == sbd_pkg::REG_ENABLE && reg_wdata[7:0] == 8'h00 |=> !irq;
  endproperty
  a_en_zero: assert property (p_en_zero) else $error("irq with all enables off");
  property p_w1c;
    (reg_wr && reg_addr == sbd_pkg::REG_EVENT && reg_wdata[7:0] == 8'hFF && quiet)
      ##1 quiet ##1 (ev_rd && quiet) |=> reg_rdata[7:0] == 8'h00;
  endproperty
  a_w1c: assert property (p_w1c) else $error("event flags survive a full clear");
  property p_txv_cause;
    tx_char_valid |-> $past(tx_char_req);
  endproperty
  a_txv_cause: assert property (p_txv_cause) else $error("tx octet with no request");
  property p_tx_hold;
    $fell(tx_char_valid) |-> $stable(tx_char_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx data moved after valid");
  property p_mode;
    reg_wr && reg_addr == sbd_pkg::REG_MODE |=> master_mode == $past(reg_wdata[0]);
  endproperty
  a_mode: assert property (p_mode) else $error("master mode not taken");
  c_clash: cover property (ev_rd ##1 reg_rdata[5]);
  c_tx: cover property (tx_char_valid ##1 !tx_char_valid);
  c_irq: cover property ($rose(irq));
endmodule : sbd_events_props
`default_nettype wire

/* File: testbench/sbd_engine_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sbd_engine_model (
  input wire logic clk,
  input wire logic tx_char_valid,
  input wire logic [7:0] tx_char_data,
  output logic slave_select_input_n,
  output logic rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic rx_overrun,
  output logic tx_char_req,
  output logic tx_underrun
);
  logic run;
  logic [1:0] tick;
  logic [7:0] got [$];
  initial begin
    slave_select_input_n = 1'h1;
    rx_char_valid = 1'h0;
    rx_overrun = 1'h0;
    tx_char_req = 1'h0;
    tx_underrun = 1'h0;
    run = 1'h0;
    rx_char_data = 8'h00;
    tick = 2'h0;
  end
  // Slow engine: one request every four cycles
  always @(posedge clk) begin
    tick <= tick + 2'h1;
    tx_char_req <= run && (tick == 2'h0);
    if (tx_char_valid) begin
      got.push_back(tx_char_data);
    end
  end
  task automatic rx(input logic [7:0] d);
    @(posedge clk);
    rx_char_valid <= 1'h1;
    rx_char_data <= d;
    @(posedge clk);
    rx_char_valid <= 1'h0;
    // Idle data line shows the inverse so a stale octet never looks fresh
    rx_char_data <= ~d;
  endtask : rx
  task automatic err(input logic is_tx);
    @(posedge clk);
    rx_overrun <= !is_tx;
    tx_underrun <= is_tx;
    @(posedge clk);
    rx_overrun <= 1'h0;
    tx_underrun <= 1'h0;
  endtask : err
  task automatic sel(input logic v);
    @(posedge clk);
    slave_select_input_n <= v;
  endtask : sel
  task automatic go(input logic v);
    @(posedge clk);
    run <= v;
  endtask : go
endmodule : sbd_engine_model
`default_nettype wire

/* File: testbench/sbd_events_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module sbd_events_tb_top;
  logic clk, rstn, ce, reg_wr, reg_rd, irq, master_mode, sel_n, rxv, rxo, txr, txv, txu;
  logic [7:0] reg_addr, rxd, txd;
  logic [15:0] reg_wdata, reg_rdata;
  int error_cnt, compares;
  always #4 clk = ~clk;
  sbd_events dut (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .master_mode(master_mode), .slave_select_input_n(sel_n), .rx_char_valid(rxv),
    .rx_char_data(rxd), .rx_overrun(rxo), .tx_char_req(txr), .tx_char_valid(txv),
    .tx_char_data(txd), .tx_underrun(txu));
  sbd_engine_model eng (.clk(clk), .tx_char_valid(txv), .tx_char_data(txd),
    .slave_select_input_n(sel_n), .rx_char_valid(rxv), .rx_char_data(rxd),
    .rx_overrun(rxo), .tx_char_req(txr), .tx_underrun(txu));
  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), v, e);
  endtask : rdc
  task automatic chkirq(input logic e);
    #1 chk("irq", {15'h0000, irq}, {15'h0000, e});
  endtask : chkirq
  task automatic evc(input logic [7:0] e);
    rdc(sbd_pkg::REG_EVENT, {8'h00, e});
    wr(sbd_pkg::REG_EVENT, 16'h00FF);
  endtask : evc
  task automatic bd(input logic [7:0] a, input logic [15:0] st, input logic [15:0] ln,
      input logic [15:0] p);
    wr(a, st);
    wr(a + 8'h01, ln);
    wr(a + 8'h02, 16'h0000);
    wr(a + 8'h03, p);
  endtask : bd
  // Polls the ownership bit with a bound; a stuck descriptor ends the run
  task automatic wait_bd(input logic [7:0] a);
    logic [15:0] v;
    for (int n = 0; n < 40; n++) begin
      rd(a, v);
      if (v[15] === 1'h0) return;
    end
    error_cnt++;
    $display("BAD descriptor %h still owned", a);
    close_out;
  endtask : wait_bd
  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    ce = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    error_cnt = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    rdc(sbd_pkg::REG_EVENT, 16'h0000);
    rdc(sbd_pkg::REG_ENABLE, 16'h0000);
    rdc(sbd_pkg::REG_RX_CHUNK, 16'h0010);
    wr(8'h10, 16'hFFFF);
    rdc(8'h10, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      wr(8'h40 + 8'(i), 16'h0000);
    end
    wr(sbd_pkg::REG_ENABLE, 16'h0037);
    rdc(sbd_pkg::REG_ENABLE, 16'h0037);
    wr(sbd_pkg::REG_RX_CHUNK, 16'h0002);
    bd(8'h40, 16'hB000, 16'h0000, 16'h0010);
    wr(sbd_pkg::REG_MODE, 16'h0003);
    eng.rx(8'hA5);
    eng.rx(8'h5A);
    rdc(8'h40, 16'h3000);
    rdc(8'h41, 16'h0002);
    rdc(8'h90, 16'h00A5);
    rdc(8'h91, 16'h005A);
    chkirq(1'h1);
    evc(8'h01);
    wr(8'h40, 16'h8000);
    eng.rx(8'hC3);
    eng.rx(8'h3C);
    rdc(8'h90, 16'h00C3);
    evc(8'h00);
    eng.rx(8'h01);
    eng.rx(8'h02);
    evc(8'h04);
    rdc(8'h44, 16'h0000);
    bd(8'h44, 16'hB200, 16'h0000, 16'h0020);
    eng.rx(8'h11);
    eng.rx(8'h22);
    rdc(8'h44, 16'hB200);
    rdc(8'h45, 16'h0002);
    evc(8'h01);
    bd(8'h48, 16'hB000, 16'h0002, 16'h0031);
    wr(8'hB1, 16'h0011);
    wr(8'hB2, 16'h0022);
    wr(sbd_pkg::REG_TX_BASE, 16'h0008);
    wr(sbd_pkg::REG_MODE, 16'h0007);
    eng.go(1'h1);
    wait_bd(8'h48);
    eng.go(1'h0);
    rdc(8'h48, 16'h3000);
    rdc(8'h49, 16'h0002);
    rdc(sbd_pkg::REG_STATUS, 16'h0800);
    chk("tx count", 16'(eng.got.size()), 16'h0002);
    chk("tx octet 0", {8'h00, eng.got[0]}, 16'h0011);
    chk("tx octet 1", {8'h00, eng.got[1]}, 16'h0022);
    evc(8'h02);
    bd(8'h40, 16'h9000, 16'h0000, 16'h0010);
    eng.sel(1'h0);
    wait_bd(8'h40);
    rdc(8'h40, 16'h1001);
    wr(sbd_pkg::REG_ENABLE, 16'h0000);
    chkirq(1'h0);
    wr(sbd_pkg::REG_ENABLE, 16'h0020);
    chkirq(1'h1);
    rdc(sbd_pkg::REG_EVENT, 16'h0021);
    wr(sbd_pkg::REG_EVENT, 16'h0020);
    chkirq(1'h0);
    rdc(sbd_pkg::REG_EVENT, 16'h0001);
    wr(sbd_pkg::REG_EVENT, 16'h00FF);
    rdc(sbd_pkg::REG_EVENT, 16'h0000);
    wr(sbd_pkg::REG_ENABLE, 16'h0037);
    wr(sbd_pkg::REG_MODE, 16'h0000);
    eng.sel(1'h1);
    bd(8'h44, 16'hB000, 16'h0000, 16'h0020);
    wr(sbd_pkg::REG_MODE, 16'h0002);
    eng.sel(1'h0);
    eng.rx(8'h3C);
    eng.sel(1'h1);
    wait_bd(8'h44);
    rdc(8'h44, 16'h3800);
    rdc(8'h45, 16'h0001);
    rdc(8'hA0, 16'h003C);
    evc(8'h01);
    bd(8'h40, 16'h9000, 16'h0000, 16'h0010);
    eng.sel(1'h0);
    eng.rx(8'h77);
    eng.err(1'h0);
    wait_bd(8'h40);
    rdc(8'h40, 16'h1002);
    rdc(8'h41, 16'h0001);
    evc(8'h01);
    bd(8'h48, 16'hB000, 16'h0004, 16'h0030);
    wr(sbd_pkg::REG_MODE, 16'h0006);
    repeat (3) @(posedge clk);
    eng.err(1'h1);
    wait_bd(8'h48);
    rdc(8'h48, 16'h3002);
    rdc(8'h49, 16'h0004);
    // Clock enable low: a clear written now must not land
    @(posedge clk);
    ce <= 1'h0;
    wr(sbd_pkg::REG_EVENT, 16'h0010);
    ce <= 1'h1;
    evc(8'h10);
    close_out;
  end
endmodule : sbd_events_tb_top
bind sbd_events sbd_events_props u_props (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .master_mode(master_mode), .rx_char_valid(rx_char_valid), .rx_overrun(rx_overrun),
  .tx_char_req(tx_char_req), .tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data),
  .tx_underrun(tx_underrun));
`default_nettype wire
